/* File: hw/angle_out_pkg.sv */
// shared constants of the angle output encoder
// assumes one core clock of 200 MHz and config words loaded from nvm
package angle_out_pkg;

   // ==========================================================
   // config word offsets
   localparam logic [7:0]  DUTY_DATA_MIN_OFS  = 8'h60;
   localparam logic [7:0]  DUTY_DATA_MAX_OFS  = 8'h62;
   localparam logic [7:0]  DUTY_DIAG_LOW_OFS  = 8'h64;
   localparam logic [7:0]  DUTY_DIAG_HIGH_OFS = 8'h66;
   localparam logic [7:0]  PERIOD_PREDIV_OFS  = 8'h68;
   localparam logic [7:0]  PERIOD_COUNT_OFS   = 8'h6a;
   localparam logic [7:0]  PROTO_CONFIG_OFS   = 8'ha2;

   // ==========================================================
   // reset values
   localparam logic [15:0] DUTY_DATA_MIN_RST  = 16'h1999;
   localparam logic [15:0] DUTY_DATA_MAX_RST  = 16'he666;
   localparam logic [15:0] DUTY_DIAG_LOW_RST  = 16'h0ccc;
   localparam logic [15:0] DUTY_DIAG_HIGH_RST = 16'hf333;
   localparam logic [15:0] PERIOD_PREDIV_RST  = 16'h0000;
   localparam logic [15:0] PERIOD_COUNT_RST   = 16'h07d0;
   localparam logic [15:0] PROTO_CONFIG_RST   = 16'h0000;

   // ==========================================================
   // output_protocol_config fields
   localparam int PROTO_SPC_BIT  = 0;
   localparam int START_RISE_BIT = 1;
   localparam int LOW_SHORT_BIT  = 2;
   localparam int TEMP_EN_BIT    = 3;
   localparam int RC_NIB_BIT     = 4;
   localparam int RC_CRC_BIT     = 5;
   localparam int TRIG_VAR_BIT   = 6;
   localparam int SSM_EN_BIT     = 7;
   localparam int UT_SEL_LSB     = 8;
   localparam int UT_SEL_W       = 4;

   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int UT_MIN_NS     = 1000;
   localparam int UT_MAX_NS     = 3000;
   localparam int UT_STEP_NS    = 200;
   localparam int UT_MIN_CYC    = UT_MIN_NS / CLK_PERIOD_NS;
   localparam int UT_STEP_CYC   = UT_STEP_NS / CLK_PERIOD_NS;
   localparam logic [3:0] UT_SEL_MAX = 4'((UT_MAX_NS - UT_MIN_NS) / UT_STEP_NS);
   localparam logic [7:0]  TRIG_CONST_UT   = 8'h5a;
   localparam logic [7:0]  TRIG_VAR_ADD_UT = 8'h0c;
   localparam logic [7:0]  NIB_BASE_UT     = 8'h0c;
   localparam logic [7:0]  LOW_LONG_UT     = 8'h05;
   localparam logic [7:0]  LOW_SHORT_UT    = 8'h03;
   localparam logic [7:0]  TRIG_ID_BASE_UT = 8'h0c;
   localparam logic [7:0]  TRIG_ID_STEP_UT = 8'h10;
   localparam logic [7:0]  TRIG_ID_TOL_UT  = 8'h03;
   localparam logic [7:0]  TRIG_LOW_MAX_UT = 8'h50;

   // ==========================================================
   // frame and checksum
   localparam int NIB_MAX = 8;
   localparam logic [3:0] CRC_SEED = 4'h5;
   localparam logic [3:0] CRC_TBL [16] = '{4'h0, 4'hd, 4'h7, 4'ha, 4'he, 4'h3,
      4'h9, 4'h4, 4'h1, 4'hc, 4'h6, 4'hb, 4'hf, 4'h2, 4'h8, 4'h5};

   function automatic logic [3:0] crc4_step(input logic [3:0] c,
                                            input logic [3:0] d);
      return CRC_TBL[c] ^ d;
   endfunction : crc4_step

endpackage : angle_out_pkg

/* File: hw/nibble_crc4.sv */
// four-bit checksum over the captured frame nibbles plus an optional
// hidden nibble; purely combinational
`timescale 1ns/1ps
`default_nettype none
module nibble_crc4
   import angle_out_pkg::*;
(
   input  wire logic [NIB_MAX*4-1:0] i_nibbles,
   input  wire logic [3:0]           i_count,
   input  wire logic [3:0]           i_extra,
   input  wire logic                 i_extra_en,
   output logic      [3:0]           o_crc
);
   import angle_out_pkg::*;

   // ==========================================================
   // table walk, then one augmenting zero step
   always_comb begin
      logic [3:0] c;
      c = CRC_SEED;
      for (int i = 0; i < NIB_MAX; i++) begin
         if (i < int'(i_count)) begin
            c = crc4_step(c, i_nibbles[4*i +: 4]);
         end
      end
      if (i_extra_en) begin
         c = crc4_step(c, i_extra);
      end
      o_crc = crc4_step(c, 4'h0);
   end

endmodule : nibble_crc4
`default_nettype wire

/* File: hw/duty_wave.sv */
// free-running duty-cycle waveform: predivided tick, period in ticks
// duty is a 16-bit fraction of the period, taken at each period start
`timescale 1ns/1ps
`default_nettype none
module duty_wave
   import angle_out_pkg::*;
#(
   parameter int W = 16
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_b,
   input  wire logic         i_en,
   input  wire logic [W-1:0] i_prediv,
   input  wire logic [W-1:0] i_period,
   input  wire logic [W-1:0] i_duty,
   input  wire logic         i_start_high,
   output logic              o_level
);
   import angle_out_pkg::*;

   typedef struct packed {
      logic [W-1:0] pre;
      logic [W-1:0] cnt;
      logic [W-1:0] on;
      logic         lvl;
   } wave_t;

   wave_t s_reg;
   wave_t s_next;

   // ==========================================================
   // duty only latched at wrap, so a mid-period change cannot glitch
   always_comb begin
      logic [2*W-1:0] prod;
      prod   = i_duty * i_period;
      s_next = s_reg;
      if (!i_en) begin
         s_next     = '0;
         s_next.lvl = !i_start_high;
      end else begin
         s_next.pre = s_reg.pre + 1'b1;
         if (s_reg.pre >= i_prediv) begin
            s_next.pre = '0;
            s_next.cnt = s_reg.cnt + 1'b1;
            if (s_reg.cnt + 1'b1 >= i_period) begin
               s_next.cnt = '0;
               s_next.on  = prod[2*W-1:W];
            end
         end
         // active phase first, polarity from the starting edge
         s_next.lvl = (s_next.cnt < s_next.on) ~^ i_start_high;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_level = s_reg.lvl;

endmodule : duty_wave
`default_nettype wire

/* File: hw/angle_out_enc.sv */
// angle output encoder: duty-cycle output or triggered nibble frames
// assumes angle, temperature and fault inputs on the core clock; the
// line, straps and config loader come from outside
`timescale 1ns/1ps
`default_nettype none
module angle_out_enc
   import angle_out_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_b,
   input  wire logic        i_line,
   output logic             o_line_out,
   output logic             o_line_oe,
   input  wire logic        i_addr_strap_a,
   input  wire logic        i_addr_strap_b,
   input  wire logic        i_cfg_we,
   input  wire logic [7:0]  i_cfg_addr,
   input  wire logic [15:0] i_cfg_wdata,
   output logic      [15:0] o_cfg_rdata,
   input  wire logic [11:0] i_angle,
   input  wire logic [7:0]  i_temp,
   input  wire logic [15:0] i_angle_base,
   input  wire logic [31:0] i_cust_id,
   input  wire logic        i_fail,
   input  wire logic        i_reset_err,
   output logic      [3:0]  o_rolling_cnt,
   output logic             o_frame_done
);
   import angle_out_pkg::*;

   // ==========================================================
   // types
   typedef enum logic [5:0] {
      S_IDLE = 6'h01,
      S_MEAS = 6'h02,
      S_WAIT = 6'h04,
      S_NLO  = 6'h08,
      S_NHI  = 6'h10,
      S_END  = 6'h20
   } st_t;

   typedef struct packed {
      logic [15:0]          duty_data_min;
      logic [15:0]          duty_data_max;
      logic [15:0]          duty_diag_low;
      logic [15:0]          duty_diag_high;
      logic [15:0]          period_predivider;
      logic [15:0]          period_count;
      logic [15:0]          output_protocol_config;
      logic [15:0]          rdata;
      logic [1:0]           line_s;
      logic                 line_d;
      logic [1:0]           sa_s;
      logic [1:0]           sb_s;
      st_t                  st;
      logic [9:0]           cyc;
      logic [7:0]           ut;
      logic [7:0]           low_ut;
      logic [2:0]           idx;
      logic [3:0]           cnt;
      logic [NIB_MAX*4-1:0] frame;
      logic [3:0]           extra;
      logic                 extra_en;
      logic [3:0]           rc;
      logic [3:0]           ssm_bit;
      logic [1:0]           ssm_word;
      logic [15:0]          duty;
      logic                 out;
      logic                 oe;
      logic                 done;
   } enc_t;

   enc_t       s_reg;
   enc_t       s_next;
   logic [3:0] crc;
   logic       wave;

   // ==========================================================
   // helpers
   function automatic logic [9:0] ut_cycles(input logic [3:0] sel);
      logic [3:0] c;
      c = (sel > UT_SEL_MAX) ? UT_SEL_MAX : sel;
      return 10'(UT_MIN_CYC + int'(c) * UT_STEP_CYC);
   endfunction : ut_cycles

   function automatic logic addr_ok(input logic [7:0] low,
                                    input logic [1:0] id);
      logic [7:0] exp;
      exp = 8'(TRIG_ID_BASE_UT + TRIG_ID_STEP_UT * id);
      return (low + TRIG_ID_TOL_UT >= exp) && (low <= exp + TRIG_ID_TOL_UT);
   endfunction : addr_ok

   // ==========================================================
   // submodules
   nibble_crc4 u_crc (
      .i_nibbles  (s_reg.frame),
      .i_count    (s_reg.cnt),
      .i_extra    (s_reg.extra),
      .i_extra_en (s_reg.extra_en),
      .o_crc      (crc)
   );

   duty_wave #(.W(16)) u_wave (
      .i_clk        (i_clk),
      .i_rst_b      (i_rst_b),
      .i_en         (!s_reg.output_protocol_config[PROTO_SPC_BIT]),
      .i_prediv     (s_reg.period_predivider),
      .i_period     (s_reg.period_count),
      .i_duty       (s_reg.duty),
      .i_start_high (s_reg.output_protocol_config[START_RISE_BIT]),
      .o_level      (wave)
   );

   // ==========================================================
   // next state
   always_comb begin
      logic [15:0]          cfg;
      logic                 triggered_nibble_protocol;
      logic                 slow_serial_message;
      logic                 rc_crc;
      logic [1:0]           id;
      logic [9:0]           ucyc;
      logic                 tick;
      logic                 fall;
      logic                 rise;
      logic [7:0]           low_len;
      logic [7:0]           low_meas;
      logic [7:0]           trig_len;
      logic [3:0]           cur;
      logic [15:0]          word;
      logic [NIB_MAX*4-1:0] fr;
      logic [27:0]          prod;
      int                   k;
      cfg      = s_reg.output_protocol_config;
      triggered_nibble_protocol      = cfg[PROTO_SPC_BIT];
      slow_serial_message      = cfg[SSM_EN_BIT];
      rc_crc   = cfg[RC_CRC_BIT];
      id       = {s_reg.sb_s[1], s_reg.sa_s[1]};
      ucyc     = ut_cycles(cfg[UT_SEL_LSB +: UT_SEL_W]);
      tick     = (s_reg.cyc == ucyc - 10'h001);
      // round to the nearest unit so the sync delay cannot lose one
      low_meas = (s_reg.cyc >= (ucyc >> 1)) ? s_reg.ut + 8'h01 : s_reg.ut;
      fall     = s_reg.line_d && !s_reg.line_s[1];
      rise     = !s_reg.line_d && s_reg.line_s[1];
      low_len  = cfg[LOW_SHORT_BIT] ? LOW_SHORT_UT : LOW_LONG_UT;
      trig_len = cfg[TRIG_VAR_BIT] ? 8'(s_reg.low_ut + TRIG_VAR_ADD_UT)
                                   : TRIG_CONST_UT;
      cur      = ({1'b0, s_reg.idx} == s_reg.cnt) ? crc
                                                  : s_reg.frame[4*s_reg.idx +: 4];
      unique case (s_reg.ssm_word)
         2'h0:    word = i_angle_base;
         2'h1:    word = {8'h00, i_temp};
         2'h2:    word = i_cust_id[31:16];
         default: word = i_cust_id[15:0];
      endcase
      prod     = 28'((s_reg.duty_data_max - s_reg.duty_data_min) * i_angle);
      fr       = '0;
      k        = 4;

      s_next        = s_reg;
      s_next.done   = 1'b0;
      // first sync stage is read by the second only
      s_next.line_s = {s_reg.line_s[0], i_line};
      s_next.line_d = s_reg.line_s[1];
      s_next.sa_s   = {s_reg.sa_s[0], i_addr_strap_a};
      s_next.sb_s   = {s_reg.sb_s[0], i_addr_strap_b};

      // config words arrive only via the loader, never from the line
      if (i_cfg_we) begin
         case (i_cfg_addr)
            DUTY_DATA_MIN_OFS:  s_next.duty_data_min          = i_cfg_wdata;
            DUTY_DATA_MAX_OFS:  s_next.duty_data_max          = i_cfg_wdata;
            DUTY_DIAG_LOW_OFS:  s_next.duty_diag_low          = i_cfg_wdata;
            DUTY_DIAG_HIGH_OFS: s_next.duty_diag_high         = i_cfg_wdata;
            PERIOD_PREDIV_OFS:  s_next.period_predivider      = i_cfg_wdata;
            PERIOD_COUNT_OFS:   s_next.period_count           = i_cfg_wdata;
            PROTO_CONFIG_OFS:   s_next.output_protocol_config = i_cfg_wdata;
            default: ;
         endcase
      end
      case (i_cfg_addr)
         DUTY_DATA_MIN_OFS:  s_next.rdata = s_reg.duty_data_min;
         DUTY_DATA_MAX_OFS:  s_next.rdata = s_reg.duty_data_max;
         DUTY_DIAG_LOW_OFS:  s_next.rdata = s_reg.duty_diag_low;
         DUTY_DIAG_HIGH_OFS: s_next.rdata = s_reg.duty_diag_high;
         PERIOD_PREDIV_OFS:  s_next.rdata = s_reg.period_predivider;
         PERIOD_COUNT_OFS:   s_next.rdata = s_reg.period_count;
         PROTO_CONFIG_OFS:   s_next.rdata = s_reg.output_protocol_config;
         default:            s_next.rdata = 16'h0000;
      endcase

      // duty choice: reset error outranks failure outranks angle
      if (i_reset_err) begin
         s_next.duty = s_reg.duty_diag_high;
      end else if (i_fail) begin
         s_next.duty = s_reg.duty_diag_low;
      end else begin
         s_next.duty = s_reg.duty_data_min + prod[27:12];
      end

      // unit time base, restarted at each nibble start and zeroed in idle
      s_next.cyc = tick ? 10'h000 : s_reg.cyc + 10'h001;
      s_next.ut  = tick ? s_reg.ut + 8'h01 : s_reg.ut;

      // capture the frame so the data cannot change mid-transfer
      fr[3:0]  = {i_reset_err, i_fail,
                  slow_serial_message ? {s_reg.ssm_bit == 4'h0, word[4'hf - s_reg.ssm_bit]}
                      : id};
      fr[7:4]  = i_angle[11:8];
      fr[11:8] = i_angle[7:4];
      fr[15:12] = i_angle[3:0];
      if (cfg[TEMP_EN_BIT]) begin
         fr[4*k +: 4]     = i_temp[7:4];
         fr[4*(k+1) +: 4] = i_temp[3:0];
         k = k + 2;
      end
      if (cfg[RC_NIB_BIT] && !rc_crc) begin
         fr[4*k +: 4] = s_reg.rc;
         k = k + 1;
      end

      unique case (s_reg.st)
         S_IDLE: begin
            s_next.cyc = '0;
            s_next.ut  = '0;
            if (triggered_nibble_protocol && fall) begin
               s_next.st = S_MEAS;
            end
         end
         S_MEAS: begin
            if (rise) begin
               s_next.low_ut = low_meas;
               // only the low time decides the address
               s_next.st = addr_ok(low_meas, id) ? S_WAIT : S_IDLE;
            end else if (s_reg.ut > TRIG_LOW_MAX_UT) begin
               s_next.st = S_IDLE;
            end
         end
         S_WAIT: begin
            if (s_reg.ut == trig_len) begin
               s_next.st       = S_NLO;
               s_next.cyc      = '0;
               s_next.ut       = '0;
               s_next.idx      = '0;
               s_next.frame    = fr;
               s_next.cnt      = 4'(k);
               s_next.extra_en = rc_crc || slow_serial_message;
               s_next.extra    = rc_crc ? {s_reg.rc[1:0], slow_serial_message ? id : 2'b00}
                                        : {2'b00, id};
            end
         end
         S_NLO: begin
            if (s_reg.ut == low_len) begin
               s_next.st = S_NHI;
            end
         end
         S_NHI: begin
            if (s_reg.ut == 8'(NIB_BASE_UT + {4'h0, cur})) begin
               s_next.cyc = '0;
               s_next.ut  = '0;
               if ({1'b0, s_reg.idx} == s_reg.cnt) begin
                  s_next.st = S_END;
               end else begin
                  s_next.idx = s_reg.idx + 3'h1;
                  s_next.st  = S_NLO;
               end
            end
         end
         S_END: begin
            if (s_reg.ut == low_len) begin
               s_next.st      = S_IDLE;
               s_next.done    = 1'b1;
               s_next.rc      = s_reg.rc + 4'h1;
               if (slow_serial_message) begin
                  s_next.ssm_bit = s_reg.ssm_bit + 4'h1;
                  if (s_reg.ssm_bit == 4'hf) begin
                     s_next.ssm_word = s_reg.ssm_word + 2'h1;
                  end
               end
            end
         end
      endcase
      // open drain in triggered mode; push-pull duty output otherwise
      s_next.oe  = !triggered_nibble_protocol || (s_next.st == S_NLO) || (s_next.st == S_END);
      s_next.out = !triggered_nibble_protocol && wave;
   end

   // ==========================================================
   // state register
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s_reg                        <= '0;
         s_reg.st                     <= S_IDLE;
         s_reg.duty_data_min          <= DUTY_DATA_MIN_RST;
         s_reg.duty_data_max          <= DUTY_DATA_MAX_RST;
         s_reg.duty_diag_low          <= DUTY_DIAG_LOW_RST;
         s_reg.duty_diag_high         <= DUTY_DIAG_HIGH_RST;
         s_reg.period_predivider      <= PERIOD_PREDIV_RST;
         s_reg.period_count           <= PERIOD_COUNT_RST;
         s_reg.output_protocol_config <= PROTO_CONFIG_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_line_out    = s_reg.out;
   assign o_line_oe     = s_reg.oe;
   assign o_cfg_rdata   = s_reg.rdata;
   assign o_rolling_cnt = s_reg.rc;
   assign o_frame_done  = s_reg.done;

   // ==========================================================
   // checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   logic spc_m;
   assign spc_m = s_reg.output_protocol_config[PROTO_SPC_BIT];

   pwm_drive_a: assert property (
      ($past(i_rst_b) && !spc_m && $past(!spc_m)) |-> o_line_oe)
      else $error("duty mode not driving line");
   spc_low_only_a: assert property (
      (spc_m && $past(spc_m) && o_line_oe) |-> !o_line_out)
      else $error("triggered mode drives high");
   foreign_trig_a: assert property (
      (s_reg.st == S_MEAS && s_next.st != S_MEAS && s_next.st != S_WAIT)
      |=> ##1 !o_line_oe [*2])
      else $error("sensor answered foreign trigger");
   diag_high_a: assert property (
      i_reset_err |=> s_reg.duty == $past(s_reg.duty_diag_high))
      else $error("reset error duty wrong");
   diag_low_a: assert property (
      (!i_reset_err && i_fail) |=> s_reg.duty == $past(s_reg.duty_diag_low))
      else $error("failure duty wrong");
   zero_angle_a: assert property (
      (!i_reset_err && !i_fail && i_angle == 12'h000)
      |=> s_reg.duty == $past(s_reg.duty_data_min))
      else $error("zero angle duty wrong");
   rc_step_a: assert property (
      o_frame_done |-> o_rolling_cnt == $past(o_rolling_cnt) + 4'h1)
      else $error("rolling counter step wrong");
   end_after_crc_a: assert property (
      (s_reg.st == S_NHI && s_next.st != S_NHI &&
       {1'b0, s_reg.idx} == s_reg.cnt) |=> s_reg.st == S_END ##1 o_line_oe)
      else $error("end pulse missing after checksum");
   status_bits_a: assert property (
      (s_reg.st == S_WAIT && s_next.st == S_NLO)
      |=> s_reg.frame[3:2] == {$past(i_reset_err), $past(i_fail)})
      else $error("status nibble flags wrong");
   ssm_step_a: assert property (
      (o_frame_done && s_reg.output_protocol_config[SSM_EN_BIT])
      |-> s_reg.ssm_bit == $past(s_reg.ssm_bit) + 4'h1)
      else $error("slow message bit not advanced");

   frame_sent_c: cover property (o_frame_done);
   trig_var_c: cover property (
      o_frame_done && s_reg.output_protocol_config[TRIG_VAR_BIT]);
   fail_duty_c: cover property (!spc_m && i_fail && !i_reset_err);

endmodule : angle_out_enc
`default_nettype wire

/* File: verification/ecu_model.sv */
// ecu side of the single wire: trigger pulses and a log of falling edges
// assumes the bench resolves the open-drain wire with a pull-up
`timescale 1ns/1ps
`default_nettype none
module ecu_model #(
   parameter int UT = 200
) (
   input  wire logic i_clk,
   input  wire logic i_line,
   output logic      o_pull_low
);
   int cyc = 0;
   int falls[$];
   initial o_pull_low = 1'b0;
   always @(posedge i_clk) cyc <= cyc + 1;
   // falls mark the trigger, each nibble and the end pulse; intervals carry the values
   always @(negedge i_line) falls.push_back(cyc);
   // low time alone picks the sensor on a shared wire
   task automatic trig(input int low_ut);
      falls.delete();
      @(negedge i_clk);
      o_pull_low = 1'b1;
      repeat (low_ut * UT) @(negedge i_clk);
      o_pull_low = 1'b0;
   endtask : trig
endmodule : ecu_model
`default_nettype wire

/* File: verification/tb.sv */
// bench for the angle encoder: duty output and triggered frames
// assumes the ecu model holds the far end of the wire
`timescale 1ns/1ps
`default_nettype none
module tb;
   import angle_out_pkg::*;
   logic        i_clk = 0, i_rst_b = 0, we = 0, fail = 0, rerr = 0;
   logic [7:0]  addr = 8'h00, temp = 8'h00;
   logic [15:0] wdata = 16'h0000, abase = 16'h0000, rdata;
   logic [11:0] angle = 12'h000;
   logic [31:0] cid = 32'h0;
   logic        out, oe, pull;
   logic        done;
   wire logic   line;
   int          failures = 0, tests_run = 0, d, hi, cnt;
   logic [15:0] ofs[8] = '{8'h60, 8'h62, 8'h64, 8'h66, 8'h68, 8'h6a, 8'ha2, 8'h70};
   logic [15:0] rst[8] = '{16'h1999, 16'he666, 16'h0ccc, 16'hf333, 16'h0000,
                           16'h07d0, 16'h0000, 16'h0000};
   assign line = ~((oe & ~out) | pull);
   always #2.5 i_clk = ~i_clk;
   angle_out_enc i_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_line(line),
      .o_line_out(out), .o_line_oe(oe), .i_addr_strap_a(1'b0),
      .i_addr_strap_b(1'b0), .i_cfg_we(we), .i_cfg_addr(addr),
      .i_cfg_wdata(wdata), .o_cfg_rdata(rdata), .i_angle(angle),
      .i_temp(temp), .i_angle_base(abase), .i_cust_id(cid), .i_fail(fail),
      .i_reset_err(rerr), .o_rolling_cnt(), .o_frame_done(done));
   ecu_model #(.UT(UT_MIN_CYC)) i_ecu (.i_clk(i_clk), .i_line(line),
      .o_pull_low(pull));
   // =========================================================
   // helpers
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(negedge i_clk);
      we = 1'b1;
      addr = a;
      wdata = v;
      @(negedge i_clk);
      we = 1'b0;
   endtask : wr
   function automatic int ut_of(input int k);
      return (i_ecu.falls[k] - i_ecu.falls[k-1] + UT_MIN_CYC / 2) / UT_MIN_CYC;
   endfunction : ut_of
   // expected frame built from the rules, then decoded off the wire
   task automatic frame(input logic [15:0] cfg, input int rc);
      int q[$];
      int crc;
      angle = 12'($urandom);
      q = '{cfg[SSM_EN_BIT] ? 2 + int'(abase[15]) : 0, int'(angle[11:8]),
            int'(angle[7:4]), int'(angle[3:0])};
      if (cfg[TEMP_EN_BIT]) q.push_back(int'(temp[7:4]));
      if (cfg[TEMP_EN_BIT]) q.push_back(int'(temp[3:0]));
      if (cfg[RC_NIB_BIT] && !cfg[RC_CRC_BIT]) q.push_back(rc);
      crc = 5;
      foreach (q[k]) crc = int'(CRC_TBL[crc]) ^ q[k];
      if (cfg[RC_CRC_BIT]) crc = int'(CRC_TBL[crc]) ^ ((rc & 3) << 2);
      else if (cfg[SSM_EN_BIT]) crc = int'(CRC_TBL[crc]);
      q.push_back(int'(CRC_TBL[crc]));
      wr(PROTO_CONFIG_OFS, cfg);
      i_ecu.trig(12);
      for (int n = 0; n < 60000 && done !== 1'b1; n++) @(negedge i_clk);
      chk(done, 1'b1);
      chk(i_ecu.falls.size(), q.size() + 2);
      chk(ut_of(1), cfg[TRIG_VAR_BIT] ? 24 : 90);
      for (int k = 0; k < q.size(); k++) chk(ut_of(k + 2) - 12, q[k]);
      $display("frame test done rc=%0d", rc);
   endtask : frame
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   // =========================================================
   // watchdog: two frames, foreign trigger and duty sweep fit inside
   initial begin
      #(95000 * CLK_PERIOD_NS);
      failures++;
      end_sim();
   end
   // =========================================================
   // main sequence
   initial begin
      void'($urandom(92));
      temp = 8'($urandom);
      abase = 16'($urandom);
      cid = $urandom;
      repeat (3) @(negedge i_clk);
      i_rst_b = 1'b1;
      for (int k = 0; k < 8; k++) begin
         @(negedge i_clk);
         addr = ofs[k][7:0];
         @(negedge i_clk);
         chk(rdata, rst[k]);
      end
      wr(PERIOD_COUNT_OFS, 16'h0064);
      @(negedge i_clk);
      chk(rdata, 16'h0064);
      $display("register test done");
      for (int k = 0; k < 5; k++) begin
         angle = (k == 0) ? 12'h000 : (k == 1) ? 12'hfff : 12'($urandom);
         fail = (k == 2 || k == 3);
         rerr = (k == 3);
         wr(PROTO_CONFIG_OFS, (k == 4) ? 16'h0000 : 16'h0002);
         d = rerr ? 'hf333 : fail ? 'h0ccc : 'h1999 + (('he666 - 'h1999) * angle >> 12);
         hi = (k == 4) ? 100 - (d * 100 >> 16) : d * 100 >> 16;
         repeat (250) @(negedge i_clk);
         cnt = 0;
         repeat (100) @(negedge i_clk) cnt += int'(line);
         chk(cnt, hi);
      end
      fail = 1'b0;
      rerr = 1'b0;
      $display("duty test done");
      frame(16'h0051, 0);
      frame(16'h00ed, 1);
      i_ecu.trig(28);
      repeat (50 * UT_MIN_CYC) @(negedge i_clk);
      chk(i_ecu.falls.size(), 1);
      $display("foreign trigger test done");
      end_sim();
   end
endmodule : tb
`default_nettype wire
